// File: logic/fpd_cmd_core.sv
// top of the power-down / id / otp command block: power state, otp mode and lock state
// assumes: busy_in and wel_in come from neighbouring status logic on clk_sys
//
// What this block does
// - deep sleep taken only on exact opcode frame
// - asleep: ignore all but release and signature
// - sleep entry delay after chip select rises
// - plain deselect leaves device in standby
// - release needs chip select high after bit eight, or at bit forty or later
// - awake release immediate, asleep waits wake delay
// - signature repeats until chip select rises
// - release ignored during program or erase cycle
// - id bytes out on falling edge msb first
// - address bit zero picks lead code, alternating
// - ident read streams maker, type, density
// - enter command selects the otp area
// - exit command returns to main array
// - otp mode blocks status and lock writes
// - otp mode blocks main array access
// - lock state readable except while asleep, repeating
// - bit0 factory lock, bit1 customer lock
// - customer lock is final until reset
// - power up starts in standby
// - lock write needs write enable first
`timescale 1ns/10ps
module fpd_cmd_core #(
    parameter logic [7:0] OTP_ENTER_OP = 8'hB1,
    parameter logic [7:0] OTP_EXIT_OP = 8'hC1,
    parameter bit FACTORY_LOCKED = 1'b0,
    parameter int SLEEP_ENTRY_NS = fpd_pkg::SLEEP_ENTRY_NS,
    parameter int WAKE_NS = fpd_pkg::WAKE_NS
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // neighbouring status logic
    input wire logic busy_in,
    input wire logic wel_in,
    output logic wel_clear,
    // state outputs
    output logic deep_sleep,
    output logic standby,
    output logic otp_mode,
    output logic array_block,
    output logic status_write_block,
    output logic otp_write_block,
    output logic [7:0] lock_state
);

    // least times round up to whole cycles
    localparam int ENTRY_CYC = (SLEEP_ENTRY_NS + fpd_pkg::CLK_NS - 1) / fpd_pkg::CLK_NS;
    localparam int WAKE_CYC = (WAKE_NS + fpd_pkg::CLK_NS - 1) / fpd_pkg::CLK_NS;
    localparam logic [fpd_pkg::DLY_W-1:0] ENTRY_LAST = fpd_pkg::DLY_W'(ENTRY_CYC - 1);
    localparam logic [fpd_pkg::DLY_W-1:0] WAKE_LAST = fpd_pkg::DLY_W'(WAKE_CYC - 1);

    if (ENTRY_CYC < 1 || ENTRY_CYC > 65536 || WAKE_CYC < 1 || WAKE_CYC > 65536) begin : g_bad
        $error("delay counts do not fit the delay counter");
    end

    typedef struct packed {
        fpd_pkg::fpd_pwr_t state;
        logic [fpd_pkg::DLY_W-1:0] cnt;
        logic cs_s1;
        logic cs_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_seen;
        logic lockdown;
        logic otp_mode;
        logic dozing;
        logic deep_sleep;
        logic standby;
        logic array_block;
        logic sr_block;
        logic otp_wr_block;
        logic wel_clear;
        logic [7:0] lock_state;
    } fpd_core_t;

    fpd_core_t q, q_next;
    fpd_link_if lk ();
    logic done;
    logic exact;
    logic rel;
    logic awake_cmd;

    ////////////////////////////////////////////////////////////////////////
    fpd_serial_link u_link (
        .sclk(sclk),
        .rst(rst),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe_n(so_oe_n),
        .lk(lk)
    );

    ////////////////////////////////////////////////////////////////////////
    // a frame is judged only once chip select is seen high again, so the
    // record words from the serial side are quiet when read
    assign done = q.cs_s2 && (q.tg_s2 != q.tg_seen);
    assign exact = lk.rec_cnt == fpd_pkg::OPCODE_BITS;
    // release on exact opcode boundary or after a signature read
    // signature read needs one full byte out
    assign rel = (lk.rec_op == fpd_pkg::OP_RELEASE) &&
        (exact || lk.rec_cnt >= fpd_pkg::RES_MIN_BITS);
    assign awake_cmd = done && exact && (q.state == fpd_pkg::ST_STANDBY);

    always_comb begin
        q_next = q;
        q_next.wel_clear = 1'b0;
        q_next.cs_s1 = cs_n;
        q_next.cs_s2 = q.cs_s1;
        q_next.tg_s1 = lk.frame_tgl;
        q_next.tg_s2 = q.tg_s1;
        if (done) begin
            q_next.tg_seen = q.tg_s2;
        end
        case (q.state)
            fpd_pkg::ST_STANDBY: begin
                if (awake_cmd && lk.rec_op == fpd_pkg::OP_SLEEP) begin
                    q_next.state = fpd_pkg::ST_ENTER;
                    q_next.cnt = ENTRY_LAST;
                end
                if (awake_cmd && lk.rec_op == OTP_ENTER_OP) begin
                    q_next.otp_mode = 1'b1;
                end
                if (awake_cmd && lk.rec_op == OTP_EXIT_OP) begin
                    q_next.otp_mode = 1'b0;
                end
                // no lock write in otp mode
                if (awake_cmd && lk.rec_op == fpd_pkg::OP_LOCK_WR && wel_in
                    && !q.otp_mode && !q.lockdown) begin
                    q_next.lockdown = 1'b1;
                    q_next.wel_clear = 1'b1;
                end
            end
            fpd_pkg::ST_ENTER: begin
                if (done && rel && !busy_in) begin
                    q_next.state = fpd_pkg::ST_WAKE;
                    q_next.cnt = WAKE_LAST;
                end else if (q.cnt == '0) begin
                    q_next.state = fpd_pkg::ST_SLEEP;
                end else begin
                    q_next.cnt = q.cnt - 1'b1;
                end
            end
            fpd_pkg::ST_SLEEP: begin
                // a running write cycle blocks release
                if (done && rel && !busy_in) begin
                    q_next.state = fpd_pkg::ST_WAKE;
                    q_next.cnt = WAKE_LAST;
                end
            end
            fpd_pkg::ST_WAKE: begin
                if (q.cnt == '0) begin
                    q_next.state = fpd_pkg::ST_STANDBY;
                end else begin
                    q_next.cnt = q.cnt - 1'b1;
                end
            end
            default: begin
                q_next.state = fpd_pkg::ST_STANDBY;
            end
        endcase
        q_next.dozing = (q_next.state == fpd_pkg::ST_ENTER) ||
            (q_next.state == fpd_pkg::ST_SLEEP);
        q_next.deep_sleep = q_next.state == fpd_pkg::ST_SLEEP;
        q_next.standby = q_next.state == fpd_pkg::ST_STANDBY;
        // main array closed in otp mode
        q_next.array_block = q_next.otp_mode;
        // status writes refused in otp mode
        q_next.sr_block = q_next.otp_mode;
        q_next.otp_wr_block = q_next.otp_mode && (q_next.lockdown || FACTORY_LOCKED);
        // bit layout of the lock state
        q_next.lock_state = fpd_pkg::LOCK_RESET;
        q_next.lock_state[fpd_pkg::FACT_BIT] = FACTORY_LOCKED;
        q_next.lock_state[fpd_pkg::CUST_BIT] = q_next.lockdown;
    end

    ////////////////////////////////////////////////////////////////////////
    // reset lands in standby
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            q <= '{state: fpd_pkg::ST_STANDBY, cs_s1: 1'b1, cs_s2: 1'b1, standby: 1'b1,
                default: '0};
        end else begin
            q <= q_next;
        end
    end

    // the customer lock resets to clear here; a real part keeps it in
    // non-volatile cells, which this block does not model
    assign lk.lock_bits = {q.lockdown, FACTORY_LOCKED};
    assign lk.asleep = q.dozing;
    assign wel_clear = q.wel_clear;
    assign deep_sleep = q.deep_sleep;
    assign standby = q.standby;
    assign otp_mode = q.otp_mode;
    assign array_block = q.array_block;
    assign status_write_block = q.sr_block;
    assign otp_write_block = q.otp_wr_block;
    assign lock_state = q.lock_state;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_dp_take;
        awake_cmd && lk.rec_op == fpd_pkg::OP_SLEEP |=> q.state == fpd_pkg::ST_ENTER
            && q.cnt == ENTRY_LAST;
    endproperty
    a_dp_take: assert property (p_dp_take) else $error("sleep frame not taken");

    property p_dp_bad;
        done && q.state == fpd_pkg::ST_STANDBY && lk.rec_op == fpd_pkg::OP_SLEEP && !exact
            |=> q.state == fpd_pkg::ST_STANDBY;
    endproperty
    a_dp_bad: assert property (p_dp_bad) else $error("bad sleep frame taken");

    property p_sleep_ignore;
        q.state == fpd_pkg::ST_SLEEP && done && !rel |=> q.state == fpd_pkg::ST_SLEEP
            && $stable(q.otp_mode) && $stable(q.lockdown);
    endproperty
    a_sleep_ignore: assert property (p_sleep_ignore) else $error("command acted in sleep");

    property p_entry_delay;
        $rose(q.deep_sleep) |-> $past(q.state) == fpd_pkg::ST_ENTER && $past(q.cnt) == '0;
    endproperty
    a_entry_delay: assert property (p_entry_delay) else $error("sleep entered early");

    property p_rdp_exact;
        q.state == fpd_pkg::ST_SLEEP && done && lk.rec_op == fpd_pkg::OP_RELEASE && !exact
            && lk.rec_cnt < fpd_pkg::RES_MIN_BITS |=> q.state == fpd_pkg::ST_SLEEP;
    endproperty
    a_rdp_exact: assert property (p_rdp_exact) else $error("ragged release taken");

    property p_wake;
        q.state == fpd_pkg::ST_SLEEP && done && rel && !busy_in |=> q.state == fpd_pkg::ST_WAKE
            && q.cnt == WAKE_LAST ##1 !q.standby [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("wake delay skipped");

    property p_busy_hold;
        q.state == fpd_pkg::ST_SLEEP && busy_in |=> q.state != fpd_pkg::ST_WAKE;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("release during busy");

    property p_otp_enter;
        awake_cmd && lk.rec_op == OTP_ENTER_OP |=> q.otp_mode ##1 q.array_block;
    endproperty
    a_otp_enter: assert property (p_otp_enter) else $error("otp mode not entered");

    property p_otp_exit;
        awake_cmd && lk.rec_op == OTP_EXIT_OP |=> !q.otp_mode ##1 !q.array_block;
    endproperty
    a_otp_exit: assert property (p_otp_exit) else $error("otp mode not left");

    property p_otp_no_lock;
        q.otp_mode && done && lk.rec_op == fpd_pkg::OP_LOCK_WR |=> $stable(q.lockdown)
            && q.sr_block;
    endproperty
    a_otp_no_lock: assert property (p_otp_no_lock) else $error("lock written in otp mode");

    property p_lock_final;
        q.lockdown |=> q.lockdown && q.lock_state[fpd_pkg::CUST_BIT];
    endproperty
    a_lock_final: assert property (p_lock_final) else $error("customer lock cleared");

    property p_write_enable_cmd_needed;
        $rose(q.lockdown) |-> $past(wel_in) && q.wel_clear;
    endproperty
    a_write_enable_cmd_needed: assert property (p_write_enable_cmd_needed) else $error("lock set without enable");

    c_sleep_wake: cover property (q.state == fpd_pkg::ST_SLEEP ##[1:1000] q.state == fpd_pkg::ST_WAKE);
    c_otp: cover property ($rose(q.otp_mode) ##[1:1000] $fell(q.otp_mode));
    c_lock: cover property ($rose(q.lockdown));

endmodule // fpd_cmd_core

// File: logic/fpd_link_if.sv
// carrier between the serial-clock side and the system-clock side
// assumes: record words are read only after chip select is seen high
`timescale 1ns/10ps
interface fpd_link_if;
    logic frame_tgl;
    logic [7:0] rec_op;
    logic [5:0] rec_cnt;
    logic [1:0] lock_bits;
    logic asleep;

    modport link (
        output frame_tgl,
        output rec_op,
        output rec_cnt,
        input lock_bits,
        input asleep
    );

    modport core (
        input frame_tgl,
        input rec_op,
        input rec_cnt,
        output lock_bits,
        output asleep
    );
endinterface

// File: logic/fpd_pkg.sv
// constants, opcodes and types for the flash power-down / id / otp command block
// assumes: opcodes arrive msb first on the serial clock, one single-wire lane
package fpd_pkg;

    // opcodes taken by this block
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_RELEASE = 8'hAB;
    localparam logic [7:0] OP_MPC = 8'h90;
    localparam logic [7:0] OP_MPC_ALT1 = 8'hDF;
    localparam logic [7:0] OP_MPC_ALT2 = 8'hEF;
    localparam logic [7:0] OP_IDENT = 8'h9F;
    localparam logic [7:0] OP_LOCK_RD = 8'h2B;
    localparam logic [7:0] OP_LOCK_WR = 8'h2F;

    // frame bit positions, counted in rising serial clock edges
    localparam logic [5:0] CNT_MAX = 6'h3F;
    localparam logic [5:0] OP_LAST_EDGE = 6'h07;
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] A0_EDGE = 6'h1F;
    localparam logic [5:0] LONG_START = 6'h20;
    localparam logic [5:0] RES_MIN_BITS = 6'h28;

    // lock state register layout
    localparam int FACT_BIT = 0;
    localparam int CUST_BIT = 1;
    localparam logic [7:0] LOCK_RESET = 8'h00;

    // timing, in ns, and delay counter width in bits
    localparam int CLK_NS = 5;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_NS = 10000;
    localparam int DLY_W = 16;

    typedef enum logic [1:0] {ST_STANDBY, ST_ENTER, ST_SLEEP, ST_WAKE} fpd_pwr_t;

    function automatic logic is_mpc(input logic [7:0] op);
        return (op == OP_MPC) || (op == OP_MPC_ALT1) || (op == OP_MPC_ALT2);
    endfunction

    // first edge of the data phase: long commands carry three extra bytes
    function automatic logic [5:0] start_of(input logic [7:0] op);
        return (is_mpc(op) || op == OP_RELEASE) ? LONG_START : OPCODE_BITS;
    endfunction

endpackage

// File: logic/fpd_serial_link.sv
// serial-clock side: opcode shifter, frame record and id / lock readout
// assumes: sclk idles between frames; cs_n high resets the frame counters
`timescale 1ns/10ps
module fpd_serial_link #(
    parameter logic [7:0] MAKER_CODE = 8'h3E, // arbitrary value
    parameter logic [7:0] TYPE_CODE = 8'h71, // arbitrary value
    parameter logic [7:0] DENSITY_CODE = 8'h09, // arbitrary value
    parameter logic [7:0] SIGNATURE = 8'h71 // arbitrary value
) (
    // link pins
    input wire logic sclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    // to the core
    fpd_link_if.link lk
);

    typedef struct packed {
        logic [5:0] bitcnt;
        logic [6:0] shift;
        logic [2:0] dbit;
        logic [1:0] dbyte;
        logic a0;
        logic [2:0] s1;
        logic [2:0] s2;
    } fpd_frame_t;

    // kept apart from the frame state: it must survive chip select high
    typedef struct packed {
        logic [7:0] op;
        logic [5:0] cnt;
        logic tgl;
    } fpd_rec_t;

    typedef struct packed {
        logic so;
        logic oe_n;
    } fpd_out_t;

    fpd_frame_t f, f_next;
    fpd_rec_t rc, rc_next;
    fpd_out_t o, o_next;
    logic frame_rst;
    logic [7:0] byte_sel;
    logic in_data;

    assign frame_rst = rst | cs_n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        f_next = f;
        rc_next = rc;
        f_next.shift = {f.shift[5:0], si};
        f_next.bitcnt = (f.bitcnt == fpd_pkg::CNT_MAX) ? f.bitcnt : f.bitcnt + 6'h01;
        rc_next.cnt = f_next.bitcnt;
        if (f.bitcnt == 6'h00) begin
            rc_next.tgl = ~rc.tgl;
        end
        if (f.bitcnt == fpd_pkg::OP_LAST_EDGE) begin
            rc_next.op = {f.shift, si};
        end
        if (f.bitcnt == fpd_pkg::A0_EDGE) begin
            f_next.a0 = si;
        end
        if (in_data) begin
            f_next.dbit = f.dbit + 3'h1;
            if (f.dbit == 3'h7) begin
                if (rc.op == fpd_pkg::OP_IDENT) begin
                    f_next.dbyte = (f.dbyte == 2'h2) ? 2'h0 : f.dbyte + 2'h1;
                end else begin
                    f_next.dbyte = {1'b0, ~f.dbyte[0]};
                end
            end
        end
        f_next.s1 = {lk.lock_bits, lk.asleep};
        f_next.s2 = f.s1;
    end

    assign in_data = (f.bitcnt >= fpd_pkg::OPCODE_BITS) &&
        (f.bitcnt >= fpd_pkg::start_of(rc.op));

    always_comb begin
        byte_sel = 8'h00;
        case (rc.op)
            fpd_pkg::OP_IDENT: byte_sel = (f.dbyte == 2'h0) ? MAKER_CODE :
                (f.dbyte == 2'h1) ? TYPE_CODE : DENSITY_CODE;
            fpd_pkg::OP_RELEASE: byte_sel = SIGNATURE;
            fpd_pkg::OP_LOCK_RD: byte_sel = {6'h00, f.s2[2:1]};
            default: begin
                if (fpd_pkg::is_mpc(rc.op)) begin
                    byte_sel = (f.dbyte[0] ^ f.a0) ? TYPE_CODE : MAKER_CODE;
                end
            end
        endcase
    end

    always_comb begin
        // msb first on the falling edge
        o_next.so = byte_sel[3'h7 - f.dbit];
        // only the signature read answers while asleep
        // lock state readable even mid write cycle
        o_next.oe_n = !(in_data && (byte_sel != 8'h00 || rc.op == fpd_pkg::OP_LOCK_RD
            || fpd_pkg::is_mpc(rc.op)) && (!f.s2[0] || rc.op == fpd_pkg::OP_RELEASE));
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            f <= '0;
        end else begin
            f <= f_next;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rc <= '0;
        end else begin
            rc <= rc_next;
        end
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            o <= '{so: 1'b0, oe_n: 1'b1};
        end else begin
            o <= o_next;
        end
    end

    assign so = o.so;
    assign so_oe_n = o.oe_n;
    assign lk.frame_tgl = rc.tgl;
    assign lk.rec_op = rc.op;
    assign lk.rec_cnt = rc.cnt;

endmodule // fpd_serial_link

// File: testbench/fpd_host_model.sv
// host serial-bus model: frames opcodes on the link and collects read data
// assumes: sclk is owned here, stands still between frames, 30 ns period
`timescale 1ns/10ps
module fpd_host_model #(
    parameter int GAP_NS = 60
) (
    // link pins
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // whole framed transfer
    // host ends reads only on byte boundaries
    task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = '0;
        cs_n = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            si = tx[63 - i];
            #15 sclk = 1'b1;
            // so moves on falling edges, so it is settled here
            rx[63 - i] = so;
            #15 sclk = 1'b0;
        end
        #10 cs_n = 1'b1;
        // a released line must not keep showing the last bit
        si = ~si;
        // stay deselected past the wake delay
        #(GAP_NS);
    endtask
endmodule // fpd_host_model

// File: testbench/test_flash_powerdown_id_otp_cmds.sv
// testbench for the power-down / id / otp command block
// assumes: short sleep and wake delays of 50 ns, host model on the link pins
`timescale 1ns/10ps
module test_flash_powerdown_id_otp_cmds;
    logic clk_sys, rst, sclk, cs_n, si, so, so_oe_n, busy_in, wel_in, wel_clear;
    logic deep_sleep, standby, otp_mode, array_block, status_write_block, otp_write_block;
    logic [7:0] lock_state;
    logic [63:0] rx;
    int mismatches, num_checks, wel_seen;
    // id codes: arbitrary values, matching the link defaults
    localparam logic [7:0] MAKER = 8'h3E;
    localparam logic [7:0] TYPE = 8'h71;
    localparam logic [7:0] DENS = 8'h09;
    localparam logic [7:0] SIG = 8'h71;
    localparam logic [7:0] OTP_EN = 8'hB1;
    localparam logic [7:0] OTP_EX = 8'hC1;
    logic [7:0] mpc_ops [3] = '{fpd_pkg::OP_MPC, fpd_pkg::OP_MPC_ALT1, fpd_pkg::OP_MPC_ALT2};

    fpd_cmd_core #(
        .OTP_ENTER_OP(OTP_EN),
        .OTP_EXIT_OP(OTP_EX),
        .SLEEP_ENTRY_NS(50),
        .WAKE_NS(50)
    ) dut (
        .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so),
        .so_oe_n(so_oe_n), .busy_in(busy_in), .wel_in(wel_in), .wel_clear(wel_clear),
        .deep_sleep(deep_sleep), .standby(standby), .otp_mode(otp_mode),
        .array_block(array_block), .status_write_block(status_write_block),
        .otp_write_block(otp_write_block), .lock_state(lock_state)
    );

    // released data line floats up through its pull-up
    fpd_host_model #(.GAP_NS(60)) host (.sclk(sclk), .cs_n(cs_n), .si(si),
        .so(so_oe_n ? 1'b1 : so));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // one-cycle pulses are counted on every rising edge
    always @(posedge clk_sys) begin
        if (wel_clear === 1'b1) wel_seen++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // opcode-only frame, then let the decode land
    task automatic cmd(input logic [7:0] op, input int n);
        host.xfer({op, 56'h0}, n, rx);
        repeat (10) @(negedge clk_sys);
    endtask

    task automatic lock_rd(input logic [7:0] exp);
        host.xfer({fpd_pkg::OP_LOCK_RD, 56'h0}, 24, rx);
        chk(rx[55:48], exp);
        chk(rx[47:40], exp);
    endtask

    task automatic poll_sleep(input int lim);
        int k;
        for (k = 0; k < lim && deep_sleep !== 1'b1; k++) @(negedge clk_sys);
        if (k == lim) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, deep_sleep, 1'b1);
            test_done();
        end
    endtask

    initial begin
        #250_000;
        mismatches++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        busy_in = 1'b0;
        wel_in = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({standby, deep_sleep, otp_mode, so_oe_n}, 8'h09);
        chk(lock_state, 8'h00);
        host.xfer({fpd_pkg::OP_IDENT, 56'h0}, 40, rx);
        chk(rx[55:48], MAKER);
        chk(rx[47:40], TYPE);
        chk(rx[39:32], DENS);
        chk(rx[31:24], MAKER);
        for (int j = 0; j < 6; j++) begin
            // address bits 1 to 7 set, they must not matter
            host.xfer({mpc_ops[j % 3], 16'h0, 7'h7F, j[0], 32'h0}, 48, rx);
            chk(rx[31:24], j[0] ? TYPE : MAKER);
            chk(rx[23:16], j[0] ? MAKER : TYPE);
        end
        lock_rd(8'h00);
        cmd(fpd_pkg::OP_LOCK_WR, 8);
        chk(lock_state, 8'h00);
        cmd(fpd_pkg::OP_SLEEP, 9);
        chk({deep_sleep, standby}, 8'h01);
        cmd(fpd_pkg::OP_RELEASE, 8);
        chk({deep_sleep, standby}, 8'h01);
        cmd(fpd_pkg::OP_SLEEP, 8);
        poll_sleep(40);
        chk({deep_sleep, standby}, 8'h02);
        wel_in = 1'b1;
        cmd(fpd_pkg::OP_LOCK_WR, 8);
        chk(lock_state, 8'h00);
        cmd(OTP_EN, 8);
        chk({deep_sleep, otp_mode}, 8'h02);
        host.xfer({fpd_pkg::OP_IDENT, 56'h0}, 32, rx);
        // asleep: the line stays released, so the pull-up shows
        chk(rx[55:48], 8'hFF);
        chk({deep_sleep, wel_seen[6:0]}, 8'h80);
        busy_in = 1'b1;
        cmd(fpd_pkg::OP_RELEASE, 8);
        chk(deep_sleep, 1'b1);
        lock_rd(8'hFF);
        busy_in = 1'b0;
        cmd(fpd_pkg::OP_RELEASE, 9);
        chk(deep_sleep, 1'b1);
        host.xfer({fpd_pkg::OP_RELEASE, 56'h0}, 48, rx);
        chk(rx[31:24], SIG);
        chk(rx[23:16], SIG);
        repeat (10) @(negedge clk_sys);
        chk({deep_sleep, standby}, 8'h01);
        cmd(OTP_EN, 8);
        chk({otp_mode, array_block, status_write_block, otp_write_block}, 8'h0E);
        cmd(fpd_pkg::OP_LOCK_WR, 8);
        chk(lock_state, 8'h00);
        cmd(OTP_EX, 8);
        chk({otp_mode, array_block, status_write_block}, 8'h00);
        cmd(fpd_pkg::OP_LOCK_WR, 8);
        chk(lock_state, 8'h02);
        chk(wel_seen[7:0], 8'h01);
        busy_in = 1'b1;
        lock_rd(8'h02);
        busy_in = 1'b0;
        cmd(fpd_pkg::OP_LOCK_WR, 8);
        chk(wel_seen[7:0], 8'h01);
        cmd(OTP_EN, 8);
        chk({otp_mode, array_block, otp_write_block}, 8'h07);
        cmd(OTP_EX, 8);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk({standby, deep_sleep, lock_state[1]}, 8'h04);
        test_done();
    end
endmodule // test_flash_powerdown_id_otp_cmds
